// file: dv/bxt_pipe_model.sv
// Purpose: fetch and load/store side that issues translation requests
// Assumes: one request per issue call, results one cycle later
// Notes: address is scrambled between requests so stale values never match
`timescale 1ns/1ps
`default_nettype none
module bxt_pipe_model (
  // clock
  input wire logic mclk,
  // translation request
  output logic xl_req,
  output logic xl_is_data,
  output logic xl_is_store,
  output logic [31:0] xl_va
);
  initial begin
    xl_req = 1'b0;
    xl_is_data = 1'b0;
    xl_is_store = 1'b0;
    xl_va = 32'hA5A5_5A5A;
  end
  // one request, held for one edge, then released and scrambled
  task issue(input logic d, input logic s, input logic [31:0] va);
    @(posedge mclk);
    xl_req <= 1'b1;
    xl_is_data <= d;
    xl_is_store <= s;
    xl_va <= va;
    @(posedge mclk);
    xl_req <= 1'b0;
    xl_is_store <= ~s;
    xl_va <= ~va;
    #1;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_bxt_top.sv
// Purpose: self-checking bench for the block translation unit
// Assumes: six entries, register bus answers with ack
// Notes: expectations are built from field layouts, not design output
`timescale 1ns/1ps
`default_nettype none
module tb_bxt_top;
  import bxt_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q, pa;
  logic ack, irq, req, isd, iss, done, invd, inv, wp, ill;
  logic [31:0] va;
  logic [2:0] ct;
  logic [3:0] be = 4'hF;
  int ill_seen = 0;
  int failures = 0, checks_done = 0, cycles = 0;
  always #4 mclk = ~mclk;
  bxt_pipe_model m (.mclk(mclk), .xl_req(req), .xl_is_data(isd),
    .xl_is_store(iss), .xl_va(va));
  bxt_top #(.ENTRIES(6), .PFN_W(20)) dut (.mclk(mclk), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(be), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .irq_o(irq), .xl_req(req), .xl_is_data(isd), .xl_is_store(iss),
    .xl_va(va), .xl_done(done), .xl_pa(pa), .xl_ctype(ct),
    .xl_inv_fault(inv), .xl_inv_is_data(invd), .xl_wp_fault(wp),
    .xl_ill_op(ill));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // classic single cycle, released after the edge that sees ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task prog(input logic [2:0] e, input logic [31:0] lim, input logic [31:0] b);
    wb(1, BXT_OFF_SELECT, {29'h0, e});
    wb(1, BXT_OFF_BOUNDS, lim);
    wb(1, BXT_OFF_BASE, b);
    wb(1, BXT_OFF_CMD, {30'h0, BXT_CMD_WRITE});
  endtask
  // expected flags packed as done, invalid, data, protect, type
  task xl(input logic d, input logic s, input logic [31:0] v,
          input logic [31:0] p, input logic [6:0] f);
    m.issue(d, s, v);
    chk("pa", pa, p);
    chk("flags", {25'h0, done, inv, invd & inv, wp, ct}, {25'h0, f});
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_cap;
    wb(0, BXT_OFF_CAP, 32'h0);
    chk("cap", q, 32'h0A00_0000);
    wb(0, 8'h80, 32'h0);
    chk("unmapped", q, 32'h0000_0000);
    // a write without all byte lanes is acked but ignored
    be <= 4'h0;
    wb(1, BXT_OFF_SELECT, 32'h5);
    be <= 4'hF;
    wb(0, BXT_OFF_SELECT, 32'h0);
    chk("partial write", q, 32'h0000_0000);
  endtask
  task t_table;
    prog(3'h1, 32'h0001_0000, 32'h0000_401E);
    prog(3'h0, 32'h0000_0000, 32'h0000_8002);
    prog(3'h3, 32'hFFFF_F000, 32'h0000_0002);
    wb(1, BXT_OFF_SELECT, 32'h1);
    wb(1, BXT_OFF_CMD, {30'h0, BXT_CMD_READ});
    wb(0, BXT_OFF_BASE, 32'h0);
    chk("base", q, 32'h0000_401E);
    wb(0, BXT_OFF_BOUNDS, 32'h0);
    chk("bounds", q, 32'h0001_0000);
  endtask
  task t_xlate;
    xl(1, 0, 32'h0001_0FFF, 32'h0011_0FFF, 7'h43);
    xl(1, 0, 32'h0001_1000, 32'h0, 7'h73);
    xl(1, 1, 32'h0001_0000, 32'h0011_0000, 7'h43);
    xl(0, 0, 32'h0000_0ABC, 32'h0020_0ABC, 7'h40);
    xl(0, 0, 32'h0000_1000, 32'h0, 7'h60);
    xl(1, 1, 32'hC000_0010, 32'h0, 7'h48);
    xl(1, 1, 32'hE000_0010, 32'h0, 7'h70);
  endtask
  task t_irq;
    wb(0, BXT_OFF_STATUS, 32'h0);
    chk("status", q, 32'h3);
    chk("irq off", {31'h0, irq}, 32'h0);
    wb(1, BXT_OFF_MASK, 32'h7);
    // irq follows a mask change one edge after the ack
    @(posedge mclk);
    chk("irq on", {31'h0, irq}, 32'h1);
    wb(1, BXT_OFF_STATUS, 32'h3);
    chk("irq clr", {31'h0, irq}, 32'h0);
    wb(1, BXT_OFF_CMD, {30'h0, BXT_CMD_PROBE});
    wb(0, BXT_OFF_STATUS, 32'h0);
    chk("probe", q, 32'h4);
    wb(1, BXT_OFF_STATUS, 32'h4);
    wb(1, BXT_OFF_CMD, {30'h0, BXT_CMD_WRAND});
    wb(0, BXT_OFF_STATUS, 32'h0);
    chk("wrand", q, 32'h4);
    chk("irq ill", {31'h0, irq}, 32'h1);
    chk("ill pulses", ill_seen, 32'h2);
  endtask
  // ---------------------------------------------------------------
  // main sequence and hang guard
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (ill === 1'b1) ill_seen++;
    if (cycles == 20000) begin
      failures++;
      end_of_test;
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    t_cap;
    t_table;
    t_xlate;
    t_irq;
    end_of_test;
  end
endmodule
`default_nettype wire

// file: hw/bxt_pkg.sv
// Purpose: constants and types for the block translation unit
// Assumes: 32-bit virtual and physical addresses, 4 KiB pages
// Notes: register offsets are byte addresses on the register bus
package bxt_pkg;
  localparam int unsigned BXT_PAGE_BITS = 12;
  localparam int unsigned BXT_VA_W = 32;
  localparam int unsigned BXT_VPN_W = 20;
  localparam int unsigned BXT_CT_W = 3;
  // register offsets (byte addresses)
  localparam logic [7:0] BXT_OFF_SELECT = 8'h00;
  localparam logic [7:0] BXT_OFF_BASE = 8'h08;
  localparam logic [7:0] BXT_OFF_BOUNDS = 8'h28;
  localparam logic [7:0] BXT_OFF_CAP = 8'h40;
  localparam logic [7:0] BXT_OFF_CMD = 8'h44;
  localparam logic [7:0] BXT_OFF_STATUS = 8'h48;
  localparam logic [7:0] BXT_OFF_MASK = 8'h4C;
  // base port layout: frame number at 6 and up, type 5:3, write 2, present 1
  localparam int unsigned BXT_BASE_PFN_LSB = 6;
  localparam int unsigned BXT_BASE_C_LSB = 3;
  localparam int unsigned BXT_BASE_D_BIT = 2;
  localparam int unsigned BXT_BASE_V_BIT = 1;
  // capability register: entry count minus one in bits 30:25
  localparam int unsigned BXT_CAP_CNT_LSB = 25;
  // command register codes
  localparam logic [1:0] BXT_CMD_WRITE = 2'h0;
  localparam logic [1:0] BXT_CMD_READ = 2'h1;
  localparam logic [1:0] BXT_CMD_PROBE = 2'h2;
  localparam logic [1:0] BXT_CMD_WRAND = 2'h3;
  // status bits
  localparam int unsigned BXT_ST_INV = 0;
  localparam int unsigned BXT_ST_WP = 1;
  localparam int unsigned BXT_ST_ILL = 2;
  localparam logic [31:0] BXT_RESET_ZERO = 32'h0000_0000;
endpackage

// file: hw/bxt_top.sv
// Overview of operation
// - entries 0 and 1, user instruction/data, always implemented
// - entries 2..5 optional; kernel regions may merge
// - capability register reports implemented entry count minus one
// - select entry by reference type and region
// - over bounds or not present gives invalid fault
// - store to write-protected entry gives protect fault
// - physical address is va plus shifted frame
// - zero bounds still maps the first page
// - select register picks entry for table operations
// - bounds port reaches selected entry limit page
// - base port carries frame, type, write, present
// - probe or random write raises illegal-opcode fault
// - entry holds limit, frame, type, write, present
//
// Purpose: base-and-bounds translation unit with wishbone register port
// Assumes: one clock; requests answered one cycle after they are taken
// Notes: ENTRIES is 2, 4 or 6; with 4 kernel regions share one pair
`timescale 1ns/1ps
`default_nettype none
module bxt_top
  import bxt_pkg::*;
#(
  parameter int unsigned ENTRIES = 6,
  parameter int unsigned PFN_W = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // translation request from the pipeline
  input wire logic xl_req,
  input wire logic xl_is_data,
  input wire logic xl_is_store,
  input wire logic [31:0] xl_va,
  // translation answer
  output logic xl_done,
  output logic [31:0] xl_pa,
  output logic [2:0] xl_ctype,
  output logic xl_inv_fault,
  output logic xl_inv_is_data,
  output logic xl_wp_fault,
  output logic xl_ill_op
);
  localparam int unsigned IW = 3;

  // ----------------------------------------------------------------
  // translation table storage
  // ----------------------------------------------------------------
  logic [BXT_VPN_W-1:0] lim_reg [ENTRIES];
  logic [PFN_W-1:0] pfn_reg [ENTRIES];
  logic [BXT_CT_W-1:0] ct_reg [ENTRIES];
  logic [ENTRIES-1:0] wp_reg;
  logic [ENTRIES-1:0] pr_reg;

  logic [IW-1:0] sel_reg;
  logic [31:0] bounds_port_reg;
  logic [31:0] base_port_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;

  // entry index from reference type and region
  function automatic logic [IW-1:0] pick_entry(input logic [31:0] va,
                                                input logic dat);
    logic [IW-1:0] r;
    r = {2'b00, dat};
    if (va[31:29] == 3'b110 && ENTRIES >= 4) begin
      r = {2'b01, dat};
    end else if (va[31:29] == 3'b111 && ENTRIES >= 6) begin
      r = {2'b10, dat};
    end else if (va[31:29] == 3'b111 && ENTRIES >= 4) begin
      r = {2'b01, dat};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i && (wb_sel_i == 4'hF);
  wire wr_sel = bus_wr && wb_adr_i == BXT_OFF_SELECT;
  wire wr_base = bus_wr && wb_adr_i == BXT_OFF_BASE;
  wire wr_bnd = bus_wr && wb_adr_i == BXT_OFF_BOUNDS;
  wire wr_cmd = bus_wr && wb_adr_i == BXT_OFF_CMD;
  wire wr_stat = bus_wr && wb_adr_i == BXT_OFF_STATUS;
  wire wr_mask = bus_wr && wb_adr_i == BXT_OFF_MASK;
  wire [1:0] cmd = wb_dat_i[1:0];
  wire sel_ok = 32'(sel_reg) < ENTRIES;
  wire do_write = wr_cmd && cmd == BXT_CMD_WRITE && sel_ok;
  wire do_read = wr_cmd && cmd == BXT_CMD_READ && sel_ok;
  wire do_ill = wr_cmd && (cmd == BXT_CMD_PROBE || cmd == BXT_CMD_WRAND);
  wire [5:0] cnt_m1 = 6'(ENTRIES - 1);
  wire [31:0] cap_val = 32'(cnt_m1) << BXT_CAP_CNT_LSB;
  wire [31:0] rd_mux =
    wb_adr_i == BXT_OFF_SELECT ? {29'h0, sel_reg} :
    wb_adr_i == BXT_OFF_BASE ? base_port_reg :
    wb_adr_i == BXT_OFF_BOUNDS ? bounds_port_reg :
    wb_adr_i == BXT_OFF_CAP ? cap_val :
    wb_adr_i == BXT_OFF_STATUS ? {29'h0, status_reg} :
    wb_adr_i == BXT_OFF_MASK ? {29'h0, mask_reg} : BXT_RESET_ZERO;

  // ----------------------------------------------------------------
  // translation datapath
  // ----------------------------------------------------------------
  wire [IW-1:0] xi = pick_entry(xl_va, xl_is_data);
  wire [31:0] bnd = {lim_reg[xi], 12'hFFF};
  wire inv = (xl_va > bnd) || !pr_reg[xi];
  wire wpf = xl_is_store && !wp_reg[xi] && !inv;
  // selected entry fields, shared with the checks below
  wire [PFN_W-1:0] sel_pfn = pfn_reg[xi];
  wire [BXT_CT_W-1:0] sel_ct = ct_reg[xi];
  wire [31:0] pa = xl_va + (32'(sel_pfn) << BXT_PAGE_BITS);

  // bus slave: ack one cycle after request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= BXT_RESET_ZERO;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : BXT_RESET_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // register bus slave and table operations
  // ----------------------------------------------------------------
  // select, port registers and table operations
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= '0;
      bounds_port_reg <= BXT_RESET_ZERO;
      base_port_reg <= BXT_RESET_ZERO;
      mask_reg <= '0;
    end else begin
      if (wr_sel) sel_reg <= wb_dat_i[IW-1:0];
      if (wr_bnd) bounds_port_reg <= {wb_dat_i[31:12], 12'h000};
      if (wr_base) base_port_reg <= wb_dat_i;
      if (wr_mask) mask_reg <= wb_dat_i[2:0];
      if (do_read) begin
        bounds_port_reg <= {lim_reg[sel_reg], 12'h000};
        base_port_reg <= {(26 - PFN_W)'(0), pfn_reg[sel_reg],
                          ct_reg[sel_reg], wp_reg[sel_reg],
                          pr_reg[sel_reg], 1'b0};
      end
    end
  end

  // table entries: one generate slice per entry
  for (genvar g = 0; g < ENTRIES; g++) begin : g_ent
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        lim_reg[g] <= '0;
        pfn_reg[g] <= '0;
        ct_reg[g] <= '0;
        wp_reg[g] <= 1'b0;
        pr_reg[g] <= 1'b0;
      end else if (do_write && 32'(sel_reg) == g) begin
        lim_reg[g] <= bounds_port_reg[31:12];
        pfn_reg[g] <= base_port_reg[BXT_BASE_PFN_LSB +: PFN_W];
        ct_reg[g] <= base_port_reg[BXT_BASE_C_LSB +: BXT_CT_W];
        wp_reg[g] <= base_port_reg[BXT_BASE_D_BIT];
        pr_reg[g] <= base_port_reg[BXT_BASE_V_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // answer path
  // ----------------------------------------------------------------
  // translation answer registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      xl_done <= 1'b0;
      xl_pa <= BXT_RESET_ZERO;
      xl_ctype <= '0;
      xl_inv_fault <= 1'b0;
      xl_inv_is_data <= 1'b0;
      xl_wp_fault <= 1'b0;
    end else begin
      xl_done <= xl_req;
      xl_inv_fault <= xl_req && inv;
      xl_inv_is_data <= xl_req && xl_is_data;
      xl_wp_fault <= xl_req && wpf;
      xl_pa <= (xl_req && !inv && !wpf) ? pa : BXT_RESET_ZERO;
      xl_ctype <= xl_req ? ct_reg[xi] : '0;
    end
  end

  // ----------------------------------------------------------------
  // status and interrupt
  // ----------------------------------------------------------------
  // sticky status, set beats clear, and interrupt
  wire [2:0] ev = {do_ill, xl_req && wpf, xl_req && inv};
  // write-one-to-clear bits; an event in the same cycle still sets
  wire [2:0] clr_bits = wr_stat ? wb_dat_i[2:0] : 3'h0;
  wire [2:0] status_next = (status_reg & ~clr_bits) | ev;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= '0;
      xl_ill_op <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      status_reg <= status_next;
      xl_ill_op <= do_ill;
      irq_o <= |(status_next & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_inv;
    @(posedge mclk) disable iff (!arst_n)
    xl_req && (xl_va > {lim_reg[xi], 12'hFFF} || !pr_reg[xi])
      |=> xl_inv_fault && xl_pa == 32'h0;
  endproperty
  a_inv: assert property (p_inv) else $error("invalid fault missed");
  property p_wp;
    @(posedge mclk) disable iff (!arst_n)
    xl_req && xl_is_store && !wp_reg[xi] && !inv |=> xl_wp_fault;
  endproperty
  a_wp: assert property (p_wp) else $error("protect fault missed");
  property p_prio;
    @(posedge mclk) disable iff (!arst_n)
    xl_inv_fault |-> !xl_wp_fault;
  endproperty
  a_prio: assert property (p_prio) else $error("both faults");
  property p_pa;
    @(posedge mclk) disable iff (!arst_n)
    xl_req && !inv && !wpf
      |=> xl_pa == $past(xl_va) + (32'($past(sel_pfn)) << BXT_PAGE_BITS);
  endproperty
  a_pa: assert property (p_pa) else $error("bad address");
  property p_zero;
    @(posedge mclk) disable iff (!arst_n)
    xl_req && pr_reg[xi] && lim_reg[xi] == '0 && xl_va[31:12] == 20'h0
      |=> !xl_inv_fault;
  endproperty
  a_zero: assert property (p_zero) else $error("first page lost");
  property p_ill;
    @(posedge mclk) disable iff (!arst_n)
    do_ill |=> xl_ill_op ##0 status_reg[BXT_ST_ILL];
  endproperty
  a_ill: assert property (p_ill) else $error("no illegal op");
  property p_sel;
    @(posedge mclk) disable iff (!arst_n)
    wr_sel |=> sel_reg == $past(wb_dat_i[IW-1:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("select lost");
  property p_rd;
    @(posedge mclk) disable iff (!arst_n)
    do_read |=> bounds_port_reg[31:12] == lim_reg[$past(sel_reg)];
  endproperty
  a_rd: assert property (p_rd) else $error("read op wrong");
  property p_ack;
    @(posedge mclk) disable iff (!arst_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  // every request is answered on the next edge
  property p_done;
    @(posedge mclk) disable iff (!arst_n)
    xl_req |=> xl_done;
  endproperty
  a_done: assert property (p_done) else $error("no answer");
  // no request leaves the answer port quiet
  property p_idle;
    @(posedge mclk) disable iff (!arst_n)
    !xl_req |=> !xl_done && !xl_inv_fault && !xl_wp_fault && xl_pa == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  // memory type of the chosen entry goes out with the answer
  property p_ct;
    @(posedge mclk) disable iff (!arst_n)
    xl_req |=> xl_ctype == $past(sel_ct);
  endproperty
  a_ct: assert property (p_ct) else $error("type lost");
  // a faulting access never shows an address
  property p_sup;
    @(posedge mclk) disable iff (!arst_n)
    xl_inv_fault || xl_wp_fault |-> xl_pa == 32'h0;
  endproperty
  a_sup: assert property (p_sup) else $error("address leaked");
  // user region always uses the first pair
  property p_user;
    @(posedge mclk) disable iff (!arst_n)
    xl_req && xl_va[31:30] != 2'b11 |-> xi == {2'b00, xl_is_data};
  endproperty
  a_user: assert property (p_user) else $error("user entry");
  // kernel region two uses the second pair when present
  property p_kern2;
    @(posedge mclk) disable iff (!arst_n)
    xl_req && xl_va[31:29] == 3'b110 && ENTRIES >= 4
      |-> xi == {2'b01, xl_is_data};
  endproperty
  a_kern2: assert property (p_kern2) else $error("kernel two entry");
  // kernel region three uses the third pair when present
  property p_kern3;
    @(posedge mclk) disable iff (!arst_n)
    xl_req && xl_va[31:29] == 3'b111 && ENTRIES >= 6
      |-> xi == {2'b10, xl_is_data};
  endproperty
  a_kern3: assert property (p_kern3) else $error("kernel three entry");
  // invalid fault carries the reference type of its request
  property p_type;
    @(posedge mclk) disable iff (!arst_n)
    xl_inv_fault |-> xl_inv_is_data == $past(xl_is_data);
  endproperty
  a_type: assert property (p_type) else $error("fault type");
  // write entry copies the bounds port into the selected entry
  property p_wrlim;
    @(posedge mclk) disable iff (!arst_n)
    do_write |=> lim_reg[$past(sel_reg)] == $past(bounds_port_reg[31:12]);
  endproperty
  a_wrlim: assert property (p_wrlim) else $error("limit not written");
  // write entry copies the present flag from the base port
  property p_wrpr;
    @(posedge mclk) disable iff (!arst_n)
    do_write |=> pr_reg[$past(sel_reg)] == $past(base_port_reg[BXT_BASE_V_BIT]);
  endproperty
  a_wrpr: assert property (p_wrpr) else $error("present not written");
  // a set invalid status bit stays until software clears it
  property p_sticky;
    @(posedge mclk) disable iff (!arst_n)
    status_reg[BXT_ST_INV] && !(wr_stat && wb_dat_i[BXT_ST_INV])
      |=> status_reg[BXT_ST_INV];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");
  // capability read returns the entry count minus one
  property p_cap;
    @(posedge mclk) disable iff (!arst_n)
    bus_req && !wb_we_i && wb_adr_i == BXT_OFF_CAP
      |=> wb_dat_o[BXT_CAP_CNT_LSB +: 6] == 6'(ENTRIES - 1);
  endproperty
  a_cap: assert property (p_cap) else $error("entry count");
  // ----------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------
  c_inv: cover property (@(posedge mclk) xl_inv_fault);
  c_wp: cover property (@(posedge mclk) xl_wp_fault);
  c_ok: cover property (@(posedge mclk) xl_done && !xl_inv_fault
                        && !xl_wp_fault);
  c_irq: cover property (@(posedge mclk) irq_o);
  c_ill: cover property (@(posedge mclk) xl_ill_op);
endmodule
`default_nettype wire
